// file: logic/pimc_pkg.sv
package pimc_pkg;

	// ********************************************************************
	// register indices and byte addresses
	// ********************************************************************
	// printed offsets are not all multiples of four, so each is an index
	localparam logic [11:0] PIMC_IDX_INT_STATUS = 12'h01b;
	localparam logic [11:0] PIMC_IDX_INT_MASK   = 12'h01f;
	localparam logic [11:0] PIMC_IDX_OP_CTRL0   = 12'h020;
	localparam logic [13:0] PIMC_ADDR_INT_STATUS = {PIMC_IDX_INT_STATUS, 2'b00};
	localparam logic [13:0] PIMC_ADDR_INT_MASK   = {PIMC_IDX_INT_MASK, 2'b00};
	localparam logic [13:0] PIMC_ADDR_OP_CTRL0   = {PIMC_IDX_OP_CTRL0, 2'b00};

	// ********************************************************************
	// field positions
	// ********************************************************************
	localparam int PIMC_BIT_PTP        = 2;
	localparam int PIMC_BIT_PHY        = 1;
	localparam int PIMC_BIT_ACL        = 0;
	localparam int PIMC_BIT_LOCAL_LB   = 7;
	localparam int PIMC_BIT_REMOTE_LB  = 6;
	localparam int PIMC_BIT_TAIL_TAG   = 2;
	localparam int PIMC_QSPLIT_LSB     = 0;

	// writable bits of each register; reserved bits read zero
	localparam logic [7:0] PIMC_MASK_WMASK = 8'h07;
	localparam logic [7:0] PIMC_OPC_WMASK  = 8'hc7;

	// ********************************************************************
	// reset values
	// ********************************************************************
	localparam logic [7:0] PIMC_RST_INT_MASK = 8'h00;
	localparam logic [7:0] PIMC_RST_OP_CTRL0 = 8'h00;
	localparam logic [7:0] PIMC_RST_STATUS   = 8'h00;
	localparam logic [2:0] PIMC_RST_QCOUNT   = 3'h1;

	// ********************************************************************
	// egress queue split encodings
	// ********************************************************************
	typedef enum logic [1:0] {
		PIMC_Q_ONE      = 2'b00,
		PIMC_Q_TWO      = 2'b01,
		PIMC_Q_FOUR     = 2'b10,
		PIMC_Q_RESERVED = 2'b11
	} pimc_qsplit_e;

	// ********************************************************************
	// axi4-lite responses
	// ********************************************************************
	localparam logic [1:0] PIMC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] PIMC_RESP_SLVERR = 2'b10;

endpackage

// file: logic/pimc_port_ctrl.sv
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - 8-bit mask gates port status onto interrupt
// - mask bit zero enables; resets to zero
// - bit 2 masks timestamp interrupt, PHY ports
// - bit 1 masks PHY interrupt, PHY ports
// - bit 0 masks access-list interrupt, all ports
// - control bit 7 loops fabric egress back
// - control bit 6 loops pins back out
// - remote loop: port receive feeds port transmit
// - control bit 2 enables tail tag, host port
// - field 1:0: 10 four, 01 two queues
// - 00 single queue at reset; 11 reserved
// - access-list status clears on mask-bit toggle
module pimc_port_ctrl
	import pimc_pkg::*;
#(
	parameter bit          HAS_PHY = 1'b1, // port carries an integrated PHY
	parameter int unsigned DATA_W  = 8     // width of the loopback data paths
) (
	input  wire logic              clock,          // core clock, 20 MHz
	input  wire logic              reset_n,        // synchronous reset, low
	input  wire logic              clk_en,         // freezes all state when low
	// axi4-lite slave
	input  wire logic [13:0]       s_axi_awaddr,   // write address
	input  wire logic              s_axi_awvalid,  // write address valid
	output logic                   s_axi_awready,  // write address ready
	input  wire logic [31:0]       s_axi_wdata,    // write data
	input  wire logic [3:0]        s_axi_wstrb,    // write byte strobes
	input  wire logic              s_axi_wvalid,   // write data valid
	output logic                   s_axi_wready,   // write data ready
	output logic [1:0]             s_axi_bresp,    // write response
	output logic                   s_axi_bvalid,   // write response valid
	input  wire logic              s_axi_bready,   // write response ready
	input  wire logic [13:0]       s_axi_araddr,   // read address
	input  wire logic              s_axi_arvalid,  // read address valid
	output logic                   s_axi_arready,  // read address ready
	output logic [31:0]            s_axi_rdata,    // read data
	output logic [1:0]             s_axi_rresp,    // read response
	output logic                   s_axi_rvalid,   // read data valid
	input  wire logic              s_axi_rready,   // read data ready
	// interrupt sources, one-cycle pulses from core logic
	input  wire logic              ev_ptp,         // combined timestamp event
	input  wire logic              ev_phy,         // integrated PHY event
	input  wire logic              ev_acl,         // access-list counter event
	output logic                   irq,            // port interrupt, high level
	// mode outputs to the MAC and queue manager
	output logic                   local_loop,     // fabric egress turned back
	output logic                   remote_loop,    // pin receive turned back
	output logic                   tail_tag_en,    // this port is the host port
	output logic [1:0]             queue_split,    // egress queue split code
	output logic [2:0]             queue_count,    // number of egress queues
	// loopback steering, port MAC side on the core clock
	input  wire logic [DATA_W-1:0] fab_tx_data,    // fabric toward egress
	input  wire logic              fab_tx_valid,   // fabric data valid
	input  wire logic [DATA_W-1:0] port_rx_data,   // received at port pins
	input  wire logic              port_rx_valid,  // received data valid
	output logic [DATA_W-1:0]      fab_rx_data,    // toward the fabric
	output logic                   fab_rx_valid,   // toward the fabric valid
	output logic [DATA_W-1:0]      port_tx_data,   // toward the port pins
	output logic                   port_tx_valid   // toward the pins valid
);

	// ********************************************************************
	// register storage
	// ********************************************************************
	logic [7:0]        int_mask_ff;
	logic [7:0]        op_ctrl_ff;
	logic [7:0]        int_status_ff;
	logic [7:0]        nxt_int_mask;
	logic [7:0]        nxt_op_ctrl;
	logic [7:0]        nxt_int_status;

	// ********************************************************************
	// bus state
	// ********************************************************************
	logic [13:0]       aw_addr_ff;
	logic [7:0]        w_byte_ff;
	logic              w_lane_ff;
	logic              awready_ff;
	logic              wready_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              arready_ff;
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	logic              irq_ff;
	logic [2:0]        qcount_ff;
	logic [DATA_W-1:0] fab_rx_data_ff;
	logic              fab_rx_valid_ff;
	logic [DATA_W-1:0] port_tx_data_ff;
	logic              port_tx_valid_ff;

	logic              do_write;
	logic              wr_mask;
	logic              wr_opc;
	logic              wr_status;
	logic [7:0]        impl_bits;

	// ********************************************************************
	// helpers
	// ********************************************************************
	// address decode shared by the read and write paths
	function automatic logic [1:0] pimc_decode(input logic [13:0] addr);
		logic [1:0] sel;
		sel = 2'd3;
		if (addr == PIMC_ADDR_INT_STATUS) begin
			sel = 2'd0;
		end else if (addr == PIMC_ADDR_INT_MASK) begin
			sel = 2'd1;
		end else if (addr == PIMC_ADDR_OP_CTRL0) begin
			sel = 2'd2;
		end
		return sel;
	endfunction

	// queue count from the split code; reserved code never stored
	function automatic logic [2:0] pimc_qcount(input logic [1:0] code);
		logic [2:0] cnt;
		cnt = 3'h1;
		case (code)
			PIMC_Q_TWO:  cnt = 3'h2;
			PIMC_Q_FOUR: cnt = 3'h4;
			default:     cnt = 3'h1;
		endcase
		return cnt;
	endfunction

	// status bits that exist on this port; timestamp and PHY need a PHY
	assign impl_bits = HAS_PHY ? 8'h07 : 8'h01;

	// ********************************************************************
	// axi4-lite write channel
	// ********************************************************************
	// address and data are taken in either order, then written together
	assign do_write  = !awready_ff && !wready_ff && !bvalid_ff;
	assign wr_status = do_write && w_lane_ff
		&& (pimc_decode(aw_addr_ff) == 2'd0);
	assign wr_mask   = do_write && w_lane_ff
		&& (pimc_decode(aw_addr_ff) == 2'd1);
	assign wr_opc    = do_write && w_lane_ff
		&& (pimc_decode(aw_addr_ff) == 2'd2);

	// write address capture
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			awready_ff <= 1'b1;
			aw_addr_ff <= 14'h0000;
		end else if (clk_en) begin
			if (s_axi_awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				aw_addr_ff <= {s_axi_awaddr[13:2], 2'b00};
			end else if (bvalid_ff && s_axi_bready) begin
				awready_ff <= 1'b1;
			end
		end
	end

	// write data capture; only byte lane 0 holds register bits
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			wready_ff <= 1'b1;
			w_byte_ff <= 8'h00;
			w_lane_ff <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				w_byte_ff <= s_axi_wdata[7:0];
				w_lane_ff <= s_axi_wstrb[0];
			end else if (bvalid_ff && s_axi_bready) begin
				wready_ff <= 1'b1;
			end
		end
	end

	// write response; unmapped addresses answer slverr and store nothing
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= PIMC_RESP_OKAY;
		end else if (clk_en) begin
			if (do_write) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= (pimc_decode(aw_addr_ff) == 2'd3)
					? PIMC_RESP_SLVERR : PIMC_RESP_OKAY;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ********************************************************************
	// register updates
	// ********************************************************************
	// mask bits are active-high disables; reserved bits stay zero
	always_comb begin
		nxt_int_mask = int_mask_ff;
		if (wr_mask) begin
			nxt_int_mask = w_byte_ff & PIMC_MASK_WMASK;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			int_mask_ff <= PIMC_RST_INT_MASK;
		end else if (clk_en) begin
			int_mask_ff <= nxt_int_mask;
		end
	end

	// a write of the reserved split code leaves the split unchanged
	always_comb begin
		nxt_op_ctrl = op_ctrl_ff;
		if (wr_opc) begin
			nxt_op_ctrl = w_byte_ff & PIMC_OPC_WMASK;
			if (w_byte_ff[1:0] == PIMC_Q_RESERVED) begin
				nxt_op_ctrl[1:0] = op_ctrl_ff[1:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			op_ctrl_ff <= PIMC_RST_OP_CTRL0;
		end else if (clk_en) begin
			op_ctrl_ff <= nxt_op_ctrl;
		end
	end

	// sticky status: events win over a clear in the same cycle
	always_comb begin
		nxt_int_status = int_status_ff;
		if (wr_status) begin
			// timestamp and PHY bits clear on a written one
			nxt_int_status[PIMC_BIT_PTP] = int_status_ff[PIMC_BIT_PTP]
				& ~w_byte_ff[PIMC_BIT_PTP];
			nxt_int_status[PIMC_BIT_PHY] = int_status_ff[PIMC_BIT_PHY]
				& ~w_byte_ff[PIMC_BIT_PHY];
		end
		// access-list bit ignores reads and writes, clears on a toggle
		if (nxt_int_mask[PIMC_BIT_ACL] != int_mask_ff[PIMC_BIT_ACL]) begin
			nxt_int_status[PIMC_BIT_ACL] = 1'b0;
		end
		nxt_int_status[PIMC_BIT_PTP] = nxt_int_status[PIMC_BIT_PTP] | ev_ptp;
		nxt_int_status[PIMC_BIT_PHY] = nxt_int_status[PIMC_BIT_PHY] | ev_phy;
		nxt_int_status[PIMC_BIT_ACL] = nxt_int_status[PIMC_BIT_ACL] | ev_acl;
		nxt_int_status = nxt_int_status & impl_bits;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			int_status_ff <= PIMC_RST_STATUS;
		end else if (clk_en) begin
			int_status_ff <= nxt_int_status;
		end
	end

	// ********************************************************************
	// interrupt output
	// ********************************************************************
	// registered, so irq follows the status and mask one cycle later
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			irq_ff <= |(int_status_ff & ~int_mask_ff & impl_bits);
		end
	end

	// ********************************************************************
	// axi4-lite read channel
	// ********************************************************************
	// one read in flight; arready drops until the data is taken
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= PIMC_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && arready_ff) begin
				arready_ff <= 1'b0;
				rvalid_ff  <= 1'b1;
				rresp_ff   <= PIMC_RESP_OKAY;
				if (pimc_decode(s_axi_araddr) == 2'd0) begin
					rdata_ff <= {24'h000000, int_status_ff};
				end else if (pimc_decode(s_axi_araddr) == 2'd1) begin
					rdata_ff <= {24'h000000, int_mask_ff};
				end else if (pimc_decode(s_axi_araddr) == 2'd2) begin
					rdata_ff <= {24'h000000, op_ctrl_ff};
				end else begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= PIMC_RESP_SLVERR;
				end
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff  <= 1'b0;
				arready_ff <= 1'b1;
			end
		end
	end

	// ********************************************************************
	// queue count
	// ********************************************************************
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			qcount_ff <= PIMC_RST_QCOUNT;
		end else if (clk_en) begin
			qcount_ff <= pimc_qcount(op_ctrl_ff[1:0]);
		end
	end

	// ********************************************************************
	// loopback steering
	// ********************************************************************
	// remote loop has no elastic buffer: rates must match, so only short
	// bursts survive; the partner is expected to keep frames few and small
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			port_tx_data_ff  <= '0;
			port_tx_valid_ff <= 1'b0;
		end else if (clk_en) begin
			if (op_ctrl_ff[PIMC_BIT_REMOTE_LB]) begin
				port_tx_data_ff  <= port_rx_data;
				port_tx_valid_ff <= port_rx_valid;
			end else if (op_ctrl_ff[PIMC_BIT_LOCAL_LB]) begin
				port_tx_data_ff  <= '0;
				port_tx_valid_ff <= 1'b0;
			end else begin
				port_tx_data_ff  <= fab_tx_data;
				port_tx_valid_ff <= fab_tx_valid;
			end
		end
	end

	// fabric side: local loop turns egress back, remote loop bypasses
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			fab_rx_data_ff  <= '0;
			fab_rx_valid_ff <= 1'b0;
		end else if (clk_en) begin
			if (op_ctrl_ff[PIMC_BIT_LOCAL_LB]) begin
				fab_rx_data_ff  <= fab_tx_data;
				fab_rx_valid_ff <= fab_tx_valid;
			end else if (op_ctrl_ff[PIMC_BIT_REMOTE_LB]) begin
				fab_rx_data_ff  <= '0;
				fab_rx_valid_ff <= 1'b0;
			end else begin
				fab_rx_data_ff  <= port_rx_data;
				fab_rx_valid_ff <= port_rx_valid;
			end
		end
	end

	// ********************************************************************
	// output drive
	// ********************************************************************
	// tail tag is only a per-port level; one host port is software's duty
	assign tail_tag_en   = op_ctrl_ff[PIMC_BIT_TAIL_TAG];
	assign local_loop    = op_ctrl_ff[PIMC_BIT_LOCAL_LB];
	assign remote_loop   = op_ctrl_ff[PIMC_BIT_REMOTE_LB];
	assign queue_split   = op_ctrl_ff[PIMC_QSPLIT_LSB +: 2];
	assign queue_count   = qcount_ff;
	assign irq           = irq_ff;
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign fab_rx_data   = fab_rx_data_ff;
	assign fab_rx_valid  = fab_rx_valid_ff;
	assign port_tx_data  = port_tx_data_ff;
	assign port_tx_valid = port_tx_valid_ff;

endmodule

`default_nettype wire

// file: verif/pimc_port_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// port control checker
// ****************************************
module pimc_port_ctrl_props
	import pimc_pkg::*;
#(
	parameter int unsigned DATA_W = 8 // loop width
) (
	input wire logic              clock,         // clock
	input wire logic              reset_n,       // reset
	input wire logic              s_axi_awvalid, // aw valid
	input wire logic              s_axi_awready, // aw ready
	input wire logic              s_axi_wvalid,  // w valid
	input wire logic              s_axi_wready,  // w ready
	input wire logic              s_axi_bvalid,  // b valid
	input wire logic              s_axi_arvalid, // ar valid
	input wire logic              s_axi_arready, // ar ready
	input wire logic              s_axi_rvalid,  // r valid
	input wire logic [31:0]       s_axi_rdata,   // r data
	input wire logic [1:0]        queue_split,   // split code
	input wire logic [2:0]        queue_count,   // queues
	input wire logic              local_loop,    // local
	input wire logic              remote_loop,   // remote
	input wire logic [DATA_W-1:0] fab_tx_data,   // fabric in
	input wire logic              fab_tx_valid,  // fabric in
	input wire logic [DATA_W-1:0] port_rx_data,  // pins in
	input wire logic              port_rx_valid, // pins in
	input wire logic [DATA_W-1:0] fab_rx_data,   // fabric out
	input wire logic              fab_rx_valid,  // fabric out
	input wire logic [DATA_W-1:0] port_tx_data,  // pins out
	input wire logic              port_tx_valid  // pins out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	// queue count that a split code should give
	function automatic logic [2:0] cnt_of(input logic [1:0] s);
		return (s == 2'b10) ? 3'h4 : (s == 2'b01) ? 3'h2 : 3'h1;
	endfunction

	// ****************************************
	// bus handshakes
	// ****************************************
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// both halves taken at one edge, register written at the next, bvalid seen after that
	chk_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	chk_read_rsvd: assert property (s_rd_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
		else $error("read answer late or upper bits set");

	// ****************************************
	// queue split and loop steering
	// ****************************************
	chk_split_legal: assert property (queue_split != PIMC_Q_RESERVED)
		else $error("reserved split code");
	chk_queue_count: assert property (queue_count == cnt_of($past(queue_split)))
		else $error("queue count wrong");
	chk_local_fab: assert property ($past(local_loop) |-> fab_rx_data == $past(fab_tx_data) && fab_rx_valid == $past(fab_tx_valid))
		else $error("local loop data wrong");
	chk_local_pins: assert property ($past(local_loop && !remote_loop) |-> !port_tx_valid)
		else $error("pins driven in local loop");
	chk_remote_tx: assert property ($past(remote_loop) |-> port_tx_data == $past(port_rx_data) && port_tx_valid == $past(port_rx_valid))
		else $error("remote loop data wrong");
	chk_remote_fab: assert property ($past(remote_loop && !local_loop) |-> !fab_rx_valid)
		else $error("fabric fed in remote loop");
	// reset zeroes the data path, so the edge after release is skipped
	chk_normal_path: assert property ($past(reset_n) && $past(!local_loop && !remote_loop) |-> port_tx_data == $past(fab_tx_data) && fab_rx_data == $past(port_rx_data))
		else $error("normal path wrong");
endmodule

bind pimc_port_ctrl pimc_port_ctrl_props #(.DATA_W(DATA_W)) i_props (
	.clock(clock), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .queue_split(queue_split),
	.queue_count(queue_count), .local_loop(local_loop), .remote_loop(remote_loop),
	.fab_tx_data(fab_tx_data), .fab_tx_valid(fab_tx_valid), .port_rx_data(port_rx_data),
	.port_rx_valid(port_rx_valid), .fab_rx_data(fab_rx_data), .fab_rx_valid(fab_rx_valid),
	.port_tx_data(port_tx_data), .port_tx_valid(port_tx_valid));
`default_nettype wire

// file: verif/pimc_port_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pimc_port_ctrl_tb_top
	import pimc_pkg::*;
;
	typedef struct packed {logic [7:0] wr; logic [7:0] rd; logic [2:0] qc;} pimc_row_s;
	logic        clock, reset_n, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, ev_ptp, ev_phy, ev_acl, irq;
	logic        lloop, rloop, ttag, ftx_v, prx_v, frx_v, ptx_v;
	logic [13:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, qsplit, r;
	logic [2:0]  qcnt;
	logic [7:0]  ftx_d, prx_d, frx_d, ptx_d;
	int          num_errors, num_checks;
	// split 11 in row three must leave the earlier 01 in place
	pimc_row_s   rows[5] = '{'{8'h86, 8'h86, 3'h4}, '{8'h79, 8'h41, 3'h2},
		'{8'h03, 8'h01, 3'h2}, '{8'hc4, 8'hc4, 3'h1}, '{8'h00, 8'h00, 3'h1}};

	pimc_port_ctrl i_dut (
		.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ev_ptp(ev_ptp), .ev_phy(ev_phy), .ev_acl(ev_acl),
		.irq(irq), .local_loop(lloop), .remote_loop(rloop), .tail_tag_en(ttag),
		.queue_split(qsplit), .queue_count(qcnt), .fab_tx_data(ftx_d),
		.fab_tx_valid(ftx_v), .port_rx_data(prx_d), .port_rx_valid(prx_v),
		.fab_rx_data(frx_d), .fab_rx_valid(frx_v), .port_tx_data(ptx_d),
		.port_tx_valid(ptx_v));

	// ****************************************
	// clock, loop traffic and watchdog
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// data changes every cycle so a stale path cannot pass
	always @(posedge clock) begin
		ftx_d <= ftx_d + 8'h01;
		prx_d <= prx_d + 8'h03;
		ftx_v <= ~ftx_v;
		prx_v <= ftx_v;
	end
	initial begin
		repeat (4000) @(posedge clock);
		num_errors++;
		finish_test();
	end

	// ****************************************
	// compare and bus tasks
	// ****************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		cmp({30'h0, got}, {30'h0, exp});
	endtask
	task automatic wr(input logic [13:0] a, input logic [31:0] v);
		@(posedge clock);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [13:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic wr_ok(input logic [13:0] a, input logic [7:0] v);
		wr(a, {24'h0, v});
		cmp_resp(r, PIMC_RESP_OKAY);
	endtask
	task automatic rd_chk(input logic [13:0] a, input logic [7:0] exp);
		rd(a);
		cmp(d, {24'h0, exp});
		cmp_resp(r, PIMC_RESP_OKAY);
	endtask
	// one-cycle event pulse, then room for status and irq to settle
	task automatic pulse(input logic [2:0] e);
		@(posedge clock);
		{ev_ptp, ev_phy, ev_acl} <= e;
		@(posedge clock);
		{ev_ptp, ev_phy, ev_acl} <= 3'h0;
		repeat (2) @(posedge clock);
	endtask
	task automatic chk_irq(input logic exp);
		@(posedge clock);
		cmp({31'h0, irq}, {31'h0, exp});
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{ev_ptp, ev_phy, ev_acl, ftx_v, prx_v} = 5'h0;
		{awaddr, araddr, wdata, ftx_d, prx_d} = '0;
		clk_en = 1'b1;
		wstrb = 4'hf;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		rd_chk(PIMC_ADDR_INT_MASK, 8'h00);
		rd_chk(PIMC_ADDR_OP_CTRL0, 8'h00);
		cmp({24'h0, lloop, rloop, ttag, qsplit, qcnt}, 32'h1);
		$display("test reset done");
		foreach (rows[i]) begin
			wr_ok(PIMC_ADDR_OP_CTRL0, rows[i].wr);
			rd_chk(PIMC_ADDR_OP_CTRL0, rows[i].rd);
			cmp({lloop, rloop, ttag, qsplit, qcnt}, {rows[i].rd[7:6], rows[i].rd[2:0], rows[i].qc});
		end
		$display("test op control done");
		wr_ok(PIMC_ADDR_INT_MASK, 8'hff);
		rd_chk(PIMC_ADDR_INT_MASK, 8'h07);
		pulse(3'h7);
		chk_irq(1'b0);
		rd_chk(PIMC_ADDR_INT_STATUS, 8'h07);
		wr_ok(PIMC_ADDR_INT_MASK, 8'h03);
		chk_irq(1'b1);
		wr_ok(PIMC_ADDR_INT_STATUS, 8'h04);
		chk_irq(1'b0);
		wr_ok(PIMC_ADDR_INT_MASK, 8'h01);
		chk_irq(1'b1);
		wr_ok(PIMC_ADDR_INT_STATUS, 8'h03);
		rd_chk(PIMC_ADDR_INT_STATUS, 8'h01);
		chk_irq(1'b0);
		wr_ok(PIMC_ADDR_INT_MASK, 8'h00);
		rd_chk(PIMC_ADDR_INT_STATUS, 8'h00);
		pulse(3'h1);
		chk_irq(1'b1);
		wr_ok(PIMC_ADDR_INT_MASK, 8'h01);
		chk_irq(1'b0);
		rd_chk(PIMC_ADDR_INT_STATUS, 8'h00);
		$display("test interrupts done");
		wr(14'h0100, 32'h5a);
		cmp_resp(r, PIMC_RESP_SLVERR);
		rd(14'h0100);
		cmp(d, 32'h0);
		cmp_resp(r, PIMC_RESP_SLVERR);
		$display("test unmapped done");
		// byte lane 0 not strobed: answered okay, nothing stored
		wstrb <= 4'he;
		wr_ok(PIMC_ADDR_OP_CTRL0, 8'h86);
		wstrb <= 4'hf;
		rd_chk(PIMC_ADDR_OP_CTRL0, 8'h00);
		$display("test strobe done");
		// second reset in mid-run with an interrupt pending
		wr_ok(PIMC_ADDR_INT_MASK, 8'h05);
		pulse(3'h2);
		chk_irq(1'b1);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		chk_irq(1'b0);
		rd_chk(PIMC_ADDR_INT_MASK, 8'h00);
		rd_chk(PIMC_ADDR_INT_STATUS, 8'h00);
		$display("test reset again done");
		finish_test();
	end
endmodule
`default_nettype wire
